// ---- shared/fdc_regs_pkg.sv ----
// constants, enumerations and carriers of the floppy rate, status and fifo register bank
// assumes one clock domain; used by every file under hdl/
package fdc_regs_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_MAIN_STATUS = 10'h3f4;
	localparam logic [9:0] IDX_DATA_PORT   = 10'h3f5;
	localparam logic [9:0] IDX_RATE_SEL    = 10'h3f8;
	localparam logic [9:0] IDX_RATE_SHADOW = 10'h3f9;
	localparam logic [9:0] IDX_DRIVE_CFG   = 10'h3fa;
	localparam int         ADDR_W          = 12;

	// rate select fields
	localparam int         RS_RATE_LSB    = 0;
	localparam int         RS_SHIFT_LSB   = 2;
	localparam int         RS_LOWPWR_BIT  = 6;
	localparam int         RS_SWRST_BIT   = 7;
	localparam logic [7:0] RATE_SEL_RESET = 8'h02;

	// drive configuration fields
	localparam int         DCFG_TABLE_LSB = 0;
	localparam int         DCFG_TYPE_LSB  = 2;
	localparam logic [3:0] DCFG_RESET     = 4'h0;

	// main status fields
	localparam int MS_REQ    = 7;
	localparam int MS_DIR    = 6;
	localparam int MS_POLLED = 5;
	localparam int MS_BUSY   = 4;

	// fifo
	localparam int         FIFO_DEPTH   = 16;
	localparam int         FIFO_AW      = 4;
	localparam logic [3:0] THRESH_RESET = 4'h1;
	localparam logic [7:0] TRACK_RESET  = 8'h00;
	localparam logic [7:0] PAD_BYTE     = 8'h00;

	// write shift codes; delays in half steps of 20.8 ns, one half step being the 2 Mbps step
	localparam logic [2:0] SHIFT_CODE_ZERO  = 3'h7;
	localparam logic [2:0] SHIFT_CODE_DEF   = 3'h0;
	localparam real        SHIFT_STEP_NS    = 41.67;
	localparam real        SHIFT_HSTEP_NS   = 20.8;
	localparam logic [3:0] DEF_SHIFT_2M     = 4'h1;
	localparam logic [3:0] DEF_SHIFT_1M     = 4'h2;
	localparam logic [3:0] DEF_SHIFT_SLOW   = 4'h6;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {RATE_250K, RATE_300K, RATE_500K, RATE_1M, RATE_2M} data_rate_t;

	// phase state from the command engine
	typedef struct packed {
		logic       xfer_en;
		logic       dir;
		logic       cmd_busy;
		logic       exec;
		logic       polled;
		logic [1:0] seek;
	} core_status_t;

	// configure command load
	typedef struct packed {
		logic       load;
		logic       fifo_en;
		logic [3:0] thresh;
		logic [7:0] track;
	} fifo_cfg_t;

endpackage : fdc_regs_pkg

// ---- hdl/fdc_byte_fifo.sv ----
// sixteen byte fifo in flip-flops with flush
// assumes push is never raised when full nor pop when empty
`timescale 1ns/1ps
`default_nettype none
module fdc_byte_fifo
	import fdc_regs_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// control
	input  wire logic                 flush,
	input  wire logic                 push,
	input  wire logic [7:0]           din,
	input  wire logic                 pop,
	// state
	output logic      [7:0]           dout,
	output logic      [FIFO_AW:0]     count,
	output logic                      empty,
	output logic                      full
);
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][7:0] mem;
		logic [FIFO_AW-1:0]         rd;
		logic [FIFO_AW-1:0]         wr;
		logic [FIFO_AW:0]           cnt;
	} fifo_t;

	fifo_t r;
	fifo_t next_r;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_r = r;
		if (flush)
		begin
			next_r.rd  = '0;
			next_r.wr  = '0;
			next_r.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				next_r.mem[r.wr] = din;
				next_r.wr        = r.wr + 4'h1;
			end
			if (pop)
				next_r.rd = r.rd + 4'h1;
			if (push && !pop)
				next_r.cnt = r.cnt + 5'h01;
			else if (pop && !push)
				next_r.cnt = r.cnt - 5'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign dout  = r.mem[r.rd];
	assign count = r.cnt;
	assign empty = (r.cnt == 5'h00);
	assign full  = (r.cnt == 5'h10);
endmodule : fdc_byte_fifo
`default_nettype wire

// ---- hdl/fdc_rate_map.sv ----
// decode of rate code, rate table, drive type and write shift code
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module fdc_rate_map
	import fdc_regs_pkg::*;
(
	// selections
	input  wire logic [1:0] rate_code,
	input  wire logic [1:0] rate_table,
	input  wire logic [1:0] drive_type,
	input  wire logic [2:0] write_shift_code,
	// decoded
	output data_rate_t      rate,
	output logic            density_out,
	output logic [1:0]      drive_density,
	output logic [3:0]      shift_halfsteps
);
	always_comb
	begin
		rate        = RATE_250K;
		density_out = 1'b0;
		unique case (rate_code)
			2'h3:
			begin
				rate        = RATE_1M;
				density_out = 1'b1;
			end
			2'h0:
			begin
				rate        = RATE_500K;
				density_out = 1'b1;
			end
			2'h1:
			begin
				if (rate_table == 2'h1)
					rate = RATE_500K;
				else if (rate_table == 2'h2)
					rate = RATE_2M;
				else
					rate = RATE_300K;
			end
			2'h2:
				rate = RATE_250K;
		endcase
		// bit 1 drives output 1, bit 0 drives output 0
		unique case (drive_type)
			2'h0: drive_density = {rate_code[0], density_out};
			2'h2: drive_density = {rate_code[0], rate_code[1]};
			2'h1: drive_density = {rate_code[0], ~density_out};
			2'h3: drive_density = {rate_code[1], rate_code[0]};
		endcase
		if (write_shift_code == SHIFT_CODE_ZERO)
			shift_halfsteps = 4'h0;
		else if (write_shift_code == SHIFT_CODE_DEF)
		begin
			if (rate == RATE_2M)
				shift_halfsteps = DEF_SHIFT_2M;
			else if (rate == RATE_1M)
				shift_halfsteps = DEF_SHIFT_1M;
			else
				shift_halfsteps = DEF_SHIFT_SLOW;
		end
		else if (rate == RATE_2M)
			shift_halfsteps = {1'b0, write_shift_code};
		else
			shift_halfsteps = {write_shift_code, 1'b0};
	end
endmodule : fdc_rate_map
`default_nettype wire

// ---- hdl/fdc_rate_status_regs.sv ----
// floppy rate select, main status and data port register bank on AXI4-Lite
// assumes a command engine on the same clock that drives the phase and
// configure carriers and the disk byte streams
//
// Functional notes
// - shift code 111 is zero delay; 001-110 step 41.67 ns, or 20.8 ns at 2M.
// - default shift code gives 20.8 ns at 2M, 41.67 at 1M, else 125 ns.
// - write shift starts at track zero; configure command may change it.
// - bit 6 enters low power; soft reset or status/data access leaves it.
// - bit 7 resets the controller like the output register reset; self clearing.
// - each rate select write with byte lane 0 strobed is copied whole into a readable shadow.
// - table 00 decodes rate codes and density output.
// - table 01 code 01 is 500K low density; table 10 code 01 is 2M.
// - drive type picks which rate and density bits reach the drive outputs.
// - main status readable any time, no wait after a transfer.
// - status bits 0 and 1 show drive 0 and 1 seeking.
// - status bit 4 shows a command in progress.
// - status bit 5 is set during polled execution phase.
// - status bit 6 gives direction: one host reads, zero host writes.
// - status bit 7 permits data access; none while it is zero.
// - all command, data and result bytes pass through the data port.
// - fifo disabled after any reset; configure enables it with threshold.
// - fifo bypassed for parameters and flushed on entering execution.
// - overrun or underrun ends the command; writes pad with zero bytes.
// - hardware reset loads rate select 02; soft reset leaves it.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fdc_rate_status_regs
	import fdc_regs_pkg::*;
(
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                SRST,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0]   AWADDR,
	input  wire logic                AWVALID,
	output logic                     AWREADY,
	input  wire logic [31:0]         WDATA,
	input  wire logic [3:0]          WSTRB,
	input  wire logic                WVALID,
	output logic                     WREADY,
	output logic [1:0]               BRESP,
	output logic                     BVALID,
	input  wire logic                BREADY,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]   ARADDR,
	input  wire logic                ARVALID,
	output logic                     ARREADY,
	output logic [31:0]              RDATA,
	output logic [1:0]               RRESP,
	output logic                     RVALID,
	input  wire logic                RREADY,
	// command engine
	input  wire core_status_t        CORE_STATUS,
	input  wire fifo_cfg_t           CORE_CFG,
	input  wire logic                CORE_RX_VALID,
	input  wire logic [7:0]          CORE_RX_DATA,
	output logic                     CORE_RX_READY,
	output logic                     CORE_TX_VALID,
	output logic [7:0]               CORE_TX_DATA,
	input  wire logic                CORE_TX_READY,
	output logic                     XFER_ERROR,
	output logic                     FIFO_SERVICE,
	output logic                     SOFT_RESET,
	// power and drive
	output logic                     LOW_POWER,
	output data_rate_t               DATA_RATE,
	output logic                     DENSITY_OUT,
	output logic [1:0]               DRIVE_DENSITY_OUT,
	output logic [3:0]               WRITE_SHIFT_HALFSTEPS,
	output logic [7:0]               SHIFT_START_TRACK
);
	typedef struct packed {
		logic              aw_held;
		logic [9:0]        aw_idx;
		logic              w_held;
		logic [7:0]        w_byte;
		logic              w_lane;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [7:0]        rdata;
		logic [1:0]        rresp;
		logic [7:0]        rate_sel;
		logic [7:0]        shadow;
		logic [3:0]        drive_cfg;
		logic              low_power;
		logic              soft_reset;
		logic              fifo_en;
		logic [3:0]        thresh;
		logic [7:0]        track;
		logic              exec_d;
		logic              xfer_err;
		data_rate_t        rate;
		logic              density;
		logic [1:0]        drv_den;
		logic [3:0]        shift;
	} regs_t;

	regs_t r;
	regs_t next_r;

	logic              fifo_flush;
	logic              fifo_push;
	logic [7:0]        fifo_din;
	logic              fifo_pop;
	logic [7:0]        fifo_head;
	logic [FIFO_AW:0]  fifo_count;
	logic              fifo_empty;
	logic              fifo_full;
	logic              fifo_active;
	logic              eff_full;
	logic              host_request;
	logic [7:0]        status;
	logic              wr_do;
	logic              rd_do;
	logic [9:0]        rd_idx;
	logic [4:0]        space;
	data_rate_t        map_rate;
	logic              map_density;
	logic [1:0]        map_drv_den;
	logic [3:0]        map_shift;

	////////////////////////////////////////////////////////////////////////
	// storage and decode

	fdc_byte_fifo u_fifo (
		.clk   (CLK),
		.srst  (SRST),
		.flush (fifo_flush),
		.push  (fifo_push),
		.din   (fifo_din),
		.pop   (fifo_pop),
		.dout  (fifo_head),
		.count (fifo_count),
		.empty (fifo_empty),
		.full  (fifo_full)
	);

	fdc_rate_map u_map (
		.rate_code        (r.rate_sel[RS_RATE_LSB +: 2]),
		.rate_table       (r.drive_cfg[DCFG_TABLE_LSB +: 2]),
		.drive_type       (r.drive_cfg[DCFG_TYPE_LSB +: 2]),
		.write_shift_code (r.rate_sel[RS_SHIFT_LSB +: 3]),
		.rate             (map_rate),
		.density_out      (map_density),
		.drive_density    (map_drv_den),
		.shift_halfsteps  (map_shift)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_r      = r;
		rd_idx      = ARADDR[ADDR_W-1:2];
		wr_do       = r.aw_held && r.w_held && !r.bvalid;
		rd_do       = ARVALID && !r.rvalid;
		fifo_active = r.fifo_en && CORE_STATUS.exec;
		eff_full    = fifo_active ? fifo_full : !fifo_empty;
		space       = 5'h10 - fifo_count;
		// request follows fifo content on host reads and fifo room on host writes
		host_request = CORE_STATUS.xfer_en &&
			(CORE_STATUS.dir ? !fifo_empty : !eff_full);

		status            = 8'h00;
		status[MS_REQ]    = host_request;
		status[MS_DIR]    = CORE_STATUS.dir;
		status[MS_POLLED] = CORE_STATUS.polled && CORE_STATUS.exec;
		status[MS_BUSY]   = CORE_STATUS.cmd_busy;
		status[1:0]       = CORE_STATUS.seek;

		fifo_flush = r.soft_reset || (CORE_STATUS.exec && !r.exec_d);
		fifo_push  = 1'b0;
		fifo_din   = CORE_RX_DATA;
		fifo_pop   = 1'b0;

		// disk side streams
		if (CORE_STATUS.dir)
		begin
			fifo_push = CORE_RX_VALID && !eff_full;
		end
		else
		begin
			fifo_pop = CORE_TX_READY && !fifo_empty;
		end
		// overrun on read, underrun on write
		next_r.xfer_err = CORE_STATUS.exec &&
			(CORE_STATUS.dir ? (CORE_RX_VALID && eff_full)
				: (CORE_TX_READY && fifo_empty));

		// write address and data taken independently
		if (AWVALID && !r.aw_held)
		begin
			next_r.aw_held = 1'b1;
			next_r.aw_idx  = AWADDR[ADDR_W-1:2];
		end
		if (WVALID && !r.w_held)
		begin
			next_r.w_held = 1'b1;
			next_r.w_byte = WDATA[7:0];
			next_r.w_lane = WSTRB[0];
		end
		if (r.bvalid && BREADY)
			next_r.bvalid = 1'b0;

		next_r.soft_reset = 1'b0;
		if (wr_do)
		begin
			next_r.aw_held = 1'b0;
			next_r.w_held  = 1'b0;
			next_r.bvalid  = 1'b1;
			next_r.bresp   = RESP_OKAY;
			case (r.aw_idx)
				IDX_RATE_SEL:
				begin
					if (r.w_lane)
					begin
						next_r.shadow   = r.w_byte;
						next_r.rate_sel = r.w_byte;
						next_r.rate_sel[RS_SWRST_BIT] = 1'b0;
						next_r.soft_reset = r.w_byte[RS_SWRST_BIT];
						if (r.w_byte[RS_LOWPWR_BIT] && !r.w_byte[RS_SWRST_BIT])
							next_r.low_power = 1'b1;
					end
				end
				IDX_DRIVE_CFG:
				begin
					if (r.w_lane)
						next_r.drive_cfg = r.w_byte[3:0];
				end
				IDX_DATA_PORT:
				begin
					next_r.low_power = 1'b0;
					// ignored unless the host may write now
					if (r.w_lane && host_request && !CORE_STATUS.dir)
					begin
						fifo_push = 1'b1;
						fifo_din  = r.w_byte;
					end
				end
				IDX_MAIN_STATUS:
					next_r.low_power = 1'b0;
				IDX_RATE_SHADOW:
					next_r.bresp = RESP_OKAY;
				default:
					next_r.bresp = RESP_SLVERR;
			endcase
		end

		// read channel
		if (r.rvalid && RREADY)
			next_r.rvalid = 1'b0;
		if (rd_do)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = RESP_OKAY;
			next_r.rdata  = 8'h00;
			case (rd_idx)
				IDX_MAIN_STATUS:
				begin
					next_r.rdata     = status;
					next_r.low_power = 1'b0;
				end
				IDX_DATA_PORT:
				begin
					next_r.low_power = 1'b0;
					if (host_request && CORE_STATUS.dir)
					begin
						next_r.rdata = fifo_head;
						fifo_pop     = 1'b1;
					end
				end
				IDX_RATE_SHADOW:
					next_r.rdata = r.shadow;
				IDX_DRIVE_CFG:
					next_r.rdata = {4'h0, r.drive_cfg};
				IDX_RATE_SEL:
					next_r.rdata = 8'h00;
				default:
					next_r.rresp = RESP_SLVERR;
			endcase
		end

		// configure command
		if (CORE_CFG.load)
		begin
			next_r.fifo_en = CORE_CFG.fifo_en;
			next_r.thresh  = (CORE_CFG.thresh == 4'h0) ? THRESH_RESET
				: CORE_CFG.thresh;
			next_r.track   = CORE_CFG.track;
		end
		// soft reset keeps rate select and shadow
		if (r.soft_reset)
		begin
			next_r.fifo_en   = 1'b0;
			next_r.thresh    = THRESH_RESET;
			next_r.track     = TRACK_RESET;
			next_r.low_power = 1'b0;
		end

		next_r.exec_d  = CORE_STATUS.exec;
		next_r.rate    = map_rate;
		next_r.density = map_density;
		next_r.drv_den = map_drv_den;
		next_r.shift   = map_shift;
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			r           <= '0;
			r.rate_sel  <= RATE_SEL_RESET;
			r.shadow    <= RATE_SEL_RESET;
			r.drive_cfg <= DCFG_RESET;
			r.thresh    <= THRESH_RESET;
			r.track     <= TRACK_RESET;
			r.rate      <= RATE_250K;
			r.bresp     <= RESP_OKAY;
			r.rresp     <= RESP_OKAY;
		end
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign AWREADY = !r.aw_held;
	assign WREADY  = !r.w_held;
	assign BVALID  = r.bvalid;
	assign BRESP   = r.bresp;
	assign ARREADY = !r.rvalid;
	assign RVALID  = r.rvalid;
	assign RRESP   = r.rresp;
	assign RDATA   = {24'h000000, r.rdata};

	assign CORE_RX_READY = CORE_STATUS.dir && !eff_full;
	assign CORE_TX_VALID = !CORE_STATUS.dir && !fifo_empty;
	assign CORE_TX_DATA  = fifo_empty ? PAD_BYTE : fifo_head;
	assign XFER_ERROR    = r.xfer_err;
	// threshold request; the host must answer in time
	assign FIFO_SERVICE  = fifo_active && (CORE_STATUS.dir
		? (fifo_count >= {1'b0, r.thresh})
		: (space >= {1'b0, r.thresh}));
	assign SOFT_RESET    = r.soft_reset;

	assign LOW_POWER             = r.low_power;
	assign DATA_RATE             = r.rate;
	assign DENSITY_OUT           = r.density;
	assign DRIVE_DENSITY_OUT     = r.drv_den;
	assign WRITE_SHIFT_HALFSTEPS = r.shift;
	assign SHIFT_START_TRACK     = r.track;
endmodule : fdc_rate_status_regs
`default_nettype wire

// ---- verification/fdc_regs_assertions.sv ----
// assertions on the ports of the rate, status and fifo register bank
// assumes a bind onto fdc_rate_status_regs; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module fdc_regs_assertions
	import fdc_regs_pkg::*;
(
	// clock and reset
	input wire logic              CLK,
	input wire logic              SRST,
	// bus
	input wire logic              AWVALID,
	input wire logic              AWREADY,
	input wire logic              WVALID,
	input wire logic              WREADY,
	input wire logic              BVALID,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic              ARVALID,
	input wire logic              ARREADY,
	input wire logic              RVALID,
	input wire logic [31:0]       RDATA,
	// core and outputs
	input wire core_status_t      CORE_STATUS,
	input wire fifo_cfg_t         CORE_CFG,
	input wire logic              SOFT_RESET,
	input wire logic              LOW_POWER,
	input wire logic [7:0]        SHIFT_START_TRACK
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	// status read in flight and the phase it sampled
	logic         st_rd;
	core_status_t cs;

	always_ff @(posedge CLK)
	begin
		if (SRST)
			st_rd <= 1'b0;
		else if (ARVALID && ARREADY)
			st_rd <= ARADDR == 12'hfd0;
		if (ARVALID && ARREADY)
			cs <= CORE_STATUS;
	end

	write_answer_a:
		assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
		else $error("write response late");
	read_answer_a:
		assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	status_fields_a:
		assert property ($rose(RVALID) && st_rd |->
			RDATA[6:0] == {cs.dir, cs.polled & cs.exec, cs.cmd_busy, 2'b00, cs.seek})
		else $error("status fields wrong");
	status_ready_a:
		assert property ($rose(RVALID) && st_rd && !cs.xfer_en |-> !RDATA[7])
		else $error("request set without transfer");
	reset_pulse_a:
		assert property (SOFT_RESET |=> !SOFT_RESET && !LOW_POWER)
		else $error("soft reset not self clearing");
	lp_access_a:
		assert property (ARVALID && ARREADY && ARADDR == 12'hfd0 |-> ##[1:2] !LOW_POWER)
		else $error("low power kept after status read");
	track_load_a:
		assert property (CORE_CFG.load && !SOFT_RESET |=>
			SHIFT_START_TRACK == $past(CORE_CFG.track))
		else $error("start track not loaded");
	track_clear_a:
		assert property (SOFT_RESET |=> SHIFT_START_TRACK == 8'h00)
		else $error("start track kept after soft reset");

	cover property (SOFT_RESET);
	cover property ($rose(RVALID) && st_rd);
	cover property (CORE_CFG.load);
endmodule : fdc_regs_assertions
`default_nettype wire

// ---- verification/fdc_host_model.sv ----
// host side axi4-lite master model of the register bank
// assumes tasks are called at a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module fdc_host_model
	import fdc_regs_pkg::*;
(
	// clock
	input  wire logic              clk,
	// write channels
	output logic [ADDR_W-1:0]      AWADDR,
	output logic                   AWVALID,
	input  wire logic              AWREADY,
	output logic [31:0]            WDATA,
	output logic [3:0]             WSTRB,
	output logic                   WVALID,
	input  wire logic              WREADY,
	input  wire logic              BVALID,
	output logic                   BREADY,
	// read channels
	output logic [ADDR_W-1:0]      ARADDR,
	output logic                   ARVALID,
	input  wire logic              ARREADY,
	input  wire logic              RVALID,
	output logic                   RREADY
);
	initial
	begin
		{AWADDR, AWVALID, WDATA, WSTRB, WVALID, ARADDR, ARVALID} = '0;
		BREADY = 1'b1;
		RREADY = 1'b1;
	end

	// address and data offered together, each released when taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
		logic aw;
		logic wd;
		aw = 1'b1;
		wd = 1'b1;
		AWADDR  <= a;
		AWVALID <= 1'b1;
		WDATA   <= {24'h0, (a == 12'hfe0) ? d & 8'hdf : d};
		WSTRB   <= s;
		WVALID  <= 1'b1;
		while (aw || wd)
		begin
			@(posedge clk);
			aw = aw && !AWREADY;
			wd = wd && !WREADY;
			AWVALID <= aw;
			WVALID  <= wd;
		end
		while (!BVALID)
			@(posedge clk);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		do
			@(posedge clk);
		while (!ARREADY);
		ARVALID <= 1'b0;
		do
			@(posedge clk);
		while (!RVALID);
	endtask : rd
endmodule : fdc_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the rate, status and fifo register bank
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb
	import fdc_regs_pkg::*;
;
	logic              CLK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic              ARVALID, ARREADY, RVALID, RREADY, rxv, rxr, txv, txr, xerr, fsvc;
	logic              sres, lp, dens;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [31:0]       WDATA, RDATA;
	logic [3:0]        WSTRB, shf;
	logic [1:0]        BRESP, RRESP, ddo;
	logic [7:0]        rxd, txd, trk, b;
	logic [7:0]        fb [16];
	core_status_t      cst;
	fifo_cfg_t         ccfg;
	data_rate_t        rate;
	int                fail_count, n_compared, seed;
	logic [33:0]       q [$];

	fdc_rate_status_regs DUT (
		.CLK, .SRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
		.BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.CORE_STATUS(cst), .CORE_CFG(ccfg), .CORE_RX_VALID(rxv), .CORE_RX_DATA(rxd),
		.CORE_RX_READY(rxr), .CORE_TX_VALID(txv), .CORE_TX_DATA(txd), .CORE_TX_READY(txr),
		.XFER_ERROR(xerr), .FIFO_SERVICE(fsvc), .SOFT_RESET(sres), .LOW_POWER(lp),
		.DATA_RATE(rate), .DENSITY_OUT(dens), .DRIVE_DENSITY_OUT(ddo),
		.WRITE_SHIFT_HALFSTEPS(shf), .SHIFT_START_TRACK(trk)
	);
	fdc_host_model u_host (
		.clk(CLK), .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BVALID,
		.BREADY, .ARADDR, .ARVALID, .ARREADY, .RVALID, .RREADY
	);

	initial
		CLK = 1'b0;
	always
		#2.5 CLK = ~CLK;

	////////////////////////////////////////////////////////////////
	task chk(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bus answers are noted by the driver and compared here
	always @(posedge CLK)
		if (BVALID && BREADY)
			chk({BRESP, 32'h0}, q.pop_front());
		else if (RVALID && RREADY)
			chk({RRESP, RDATA}, q.pop_front());

	task w(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] e);
		q.push_back({e, 32'h0});
		u_host.wr(a, d, s);
	endtask : w

	task r(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		q.push_back({e, 24'h0, d});
		u_host.rd(a);
	endtask : r

	task tick(input int n);
		repeat (n) @(posedge CLK);
	endtask : tick

	function automatic logic [7:0] st(input core_status_t s, input logic rq);
		return {s.xfer_en & rq, s.dir, s.polled & s.exec, s.cmd_busy, 2'b00, s.seek};
	endfunction : st

	// rate tables 00 to 10, every drive type, rate code and shift code
	task rate_sweep;
		logic       ed;
		logic [1:0] cc;
		logic [1:0] edd;
		logic [3:0] es;
		data_rate_t er;
		for (int t = 0; t < 3; t++)
			for (int ty = 0; ty < 4; ty++)
			begin
				w(12'hfe8, 8'(ty * 4 + t), 4'h1, RESP_OKAY);
				for (int c = 0; c < 4; c++)
					for (int p = 0; p < 8; p++)
					begin
						cc = 2'(c);
						w(12'hfe0, 8'(p * 4 + c), 4'h1, RESP_OKAY);
						tick(2);
						er = cc == 3 ? RATE_1M : cc == 0 ? RATE_500K : cc == 2 ? RATE_250K :
							t == 1 ? RATE_500K : t == 2 ? RATE_2M : RATE_300K;
						ed = cc == 3 || cc == 0;
						case (ty)
							0: edd = {cc[0], ed};
							1: edd = {cc[0], !ed};
							2: edd = {cc[0], cc[1]};
							default: edd = {cc[1], cc[0]};
						endcase
						es = p == 7 ? 4'h0 : p != 0 ? (er == RATE_2M ? 4'(p) : 4'(2 * p)) :
							er == RATE_2M ? 4'h1 : er == RATE_1M ? 4'h2 : 4'h6;
						chk(rate, er);
						chk(dens, ed);
						chk(ddo, edd);
						chk(shf, es);
					end
			end
	endtask : rate_sweep

	task final_report;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (60000) @(posedge CLK);
		fail_count++;
		$display("wrong value at %0t: timeout", $time);
		final_report;
	end

	initial
	begin
		seed = 18163;
		{fail_count, n_compared, cst, ccfg, rxv, rxd, txr} = '0;
		SRST = 1'b1;
		tick(6);
		SRST <= 1'b0;
		tick(2);
		r(12'hfe4, 8'h02, RESP_OKAY);
		r(12'hfe0, 8'h00, RESP_OKAY);
		r(12'h000, 8'h00, RESP_SLVERR);
		w(12'h004, 8'hff, 4'h1, RESP_SLVERR);
		chk(rate, RATE_250K);
		chk(shf, 4'h6);
		rate_sweep;
		r(12'hfe8, 8'h0e, RESP_OKAY);
		repeat (4)
		begin
			b = 8'($random(seed)) & 8'h1f;
			w(12'hfe0, b, 4'h1, RESP_OKAY);
			r(12'hfe4, b, RESP_OKAY);
		end
		w(12'hfe0, 8'h42, 4'h1, RESP_OKAY);
		tick(2);
		chk(lp, 1'b1);
		w(12'hfe0, 8'h83, 4'h0, RESP_OKAY);
		tick(2);
		chk(rate, RATE_250K);
		w(12'hfe0, 8'h83, 4'h1, RESP_OKAY);
		tick(2);
		chk(lp, 1'b0);
		chk(rate, RATE_1M);
		r(12'hfe4, 8'h83, RESP_OKAY);
		w(12'hfe0, 8'h42, 4'h1, RESP_OKAY);
		repeat (8)
		begin
			cst <= 7'($random(seed));
			tick(1);
			r(12'hfd0, st(cst, !cst.dir), RESP_OKAY);
		end
		chk(lp, 1'b0);
		w(12'hfe0, 8'h42, 4'h1, RESP_OKAY);
		chk(lp, 1'b1);
		w(12'hfd0, 8'h00, 4'h1, RESP_OKAY);
		chk(lp, 1'b0);
		cst <= 7'h50;
		tick(1);
		r(12'hfd0, 8'h90, RESP_OKAY);
		w(12'hfd4, 8'h5a, 4'h1, RESP_OKAY);
		tick(1);
		chk({txv, txd}, 9'h15a);
		r(12'hfd0, 8'h10, RESP_OKAY);
		txr <= 1'b1;
		@(posedge CLK);
		txr <= 1'b0;
		ccfg <= {1'b1, 1'b1, 4'h4, 8'h05};
		@(posedge CLK);
		ccfg <= '0;
		cst <= 7'h78;
		tick(1);
		chk({txv, trk}, 9'h005);
		for (int i = 0; i < 16; i++)
		begin
			fb[i] = 8'($random(seed));
			rxd <= fb[i];
			rxv <= 1'b1;
			do
				@(posedge CLK);
			while (!rxr);
		end
		#1 chk({rxr, fsvc}, 2'b01);
		@(posedge CLK);
		#1 chk(xerr, 1'b1);
		@(posedge CLK);
		rxv <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			r(12'hfd0, 8'hd0, RESP_OKAY);
			r(12'hfd4, fb[i], RESP_OKAY);
		end
		r(12'hfd0, 8'h50, RESP_OKAY);
		r(12'hfd4, 8'h00, RESP_OKAY);
		cst <= 7'h58;
		txr <= 1'b1;
		tick(2);
		#1 chk({xerr, txv, txd}, 10'h200);
		@(posedge CLK);
		txr <= 1'b0;
		cst <= '0;
		SRST <= 1'b1;
		tick(2);
		SRST <= 1'b0;
		tick(2);
		r(12'hfe4, 8'h02, RESP_OKAY);
		chk(rate, RATE_250K);
		final_report;
	end
endmodule : tb

bind fdc_rate_status_regs fdc_regs_assertions u_chk (
	.CLK, .SRST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .ARADDR, .ARVALID, .ARREADY,
	.RVALID, .RDATA, .CORE_STATUS, .CORE_CFG, .SOFT_RESET, .LOW_POWER, .SHIFT_START_TRACK
);
`default_nettype wire
